// *** lfmc_pkg.sv ***
// Function
// - mode field 00 stops the converter and disconnects the load.
// - mode field 01 drives the DC-light level, ignoring strobe and software flash.
// - in DC light the mode field must be rewritten within 11.2 s, else shutdown.
// - mode field 11 regulates output voltage from the four-bit voltage code.
// - in voltage mode all three sinks are off and the safety timer is disabled.
// - mode field 10 fires flash from strobe or software bit; flash follows a level strobe, an edge strobe runs it to timeout.
// - voltage mode is forced by software bit or pin; mode field decodes otherwise.
// - output voltage spans 3.825 V to 5.7 V in 125 mV steps.
// - a programmable safety timer limits the flash pulse length.
// - LED current ramps in steps; up 12 us or 0.5 us, down 0.5 us.
// - high-current select scales every current setting by 2.25.
// - power-save bit selects pulse skipping, else fixed frequency.
// - down-conversion keeps power save on regardless of the bit.
// - enter down-conversion when input reaches output; leave about 200 mV below.
// - strobe switches DC to flash level at once; a pin may also enable DC light.
// - the control interface accepts mode, brightness, voltage and timer writes.
// - timer starts on trigger rise, stops on timeout or, with level strobe type, on low level; timeout clears software trigger.
package lfmc_pkg;
  // ==========================================================================
  // timing
  localparam int REF_CLK_MHZ = 100;
  localparam int WDOG_MS = 11200;
  localparam int WDOG_CYC = WDOG_MS * 1000 * REF_CLK_MHZ;
  localparam int SAFETY_STEP_MS = 50;
  localparam int SAFETY_STEP_CYC = SAFETY_STEP_MS * 1000 * REF_CLK_MHZ;
  localparam int RAMP_UP_DD_NS = 12000;
  localparam int RAMP_UP_HC_NS = 500;
  localparam int RAMP_DN_NS = 500;
  localparam int RAMP_UP_DD_CYC = (RAMP_UP_DD_NS * REF_CLK_MHZ) / 1000;
  localparam int RAMP_UP_HC_CYC = (RAMP_UP_HC_NS * REF_CLK_MHZ) / 1000;
  localparam int RAMP_DN_CYC = (RAMP_DN_NS * REF_CLK_MHZ) / 1000;
  // ==========================================================================
  // analog scaling (current in quarter milliamps)
  localparam logic [12:0] VOUT_BASE_MV = 13'h0EF1;
  localparam logic [12:0] VOUT_STEP_MV = 13'h007D;
  localparam logic [3:0] VM_PRESET_CODE = 4'h9;
  localparam logic [11:0] ISTEP_DD_QMA = 12'h064;
  localparam logic [11:0] ISTEP_HC_QMA = 12'h0E1;
  // ==========================================================================
  // register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LEVEL_OFS = 8'h04;
  localparam logic [7:0] VOUT_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SWTRIG_BIT = 2;
  localparam int CTRL_VMF_BIT = 3;
  localparam int CTRL_PSM_BIT = 4;
  localparam int CTRL_STRTYPE_BIT = 5;
  localparam int LEVEL_DC_LSB = 0;
  localparam int LEVEL_FL_LSB = 4;
  localparam int LEVEL_SINK_LSB = 8;
  localparam int VOUT_CODE_LSB = 0;
  localparam int VOUT_TIMER_LSB = 4;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_RUN_BIT = 2;
  localparam int STAT_HOLD_BIT = 3;
  localparam int STAT_DOWN_BIT = 4;
  localparam int STAT_VMPIN_BIT = 5;
  localparam int STAT_HC_BIT = 6;
  localparam int STAT_CUR_LSB = 8;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [3:0] LEVEL_RST = 4'h0;
  localparam logic [2:0] SINK_RST = 3'h7;
  localparam logic [3:0] VCODE_RST = 4'h0;
  localparam logic [2:0] TIMER_RST = 3'h0;
  // ==========================================================================
  // modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_DCL = 2'h1;
  localparam logic [1:0] MODE_FLASH = 2'h2;
  localparam logic [1:0] MODE_VOLT = 2'h3;
  typedef enum logic [1:0] {ST_SHUTDOWN, ST_DCLIGHT, ST_FLASH, ST_VOLTAGE} lfmc_state_type;
  typedef struct packed {
    logic [1:0] operating_mode;
    logic software_flash_trigger;
    logic voltage_mode_force;
    logic power_save_enable;
    logic strobe_type_select;
    logic [3:0] dc_light_current_level;
    logic [3:0] flash_current_level;
    logic [2:0] led_sink_enables;
    logic [3:0] output_voltage_code;
    logic [2:0] flash_safety_timer_setting;
  } lfmc_cfg_type;
endpackage

// *** lfmc_link.sv ***
`timescale 1ns/1ps
module lfmc_link (
  input wire logic link_clk,
  input wire logic nrst,
  input wire logic strobe_pin,
  input wire logic flash_arm,
  output logic strobe_lvl,
  output logic flash_sel
);
  // ==========================================================================
  // link-domain reset and pin capture
  logic [1:0] rst_q;
  logic strobe_m_q, strobe_s_q, arm_m_q, arm_s_q, strobe_lvl_q, flash_sel_q;
  logic strobe_lvl_d, flash_sel_d;
  always_comb begin
    strobe_lvl_d = strobe_s_q;
    flash_sel_d = strobe_s_q & arm_s_q;
  end
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  always_ff @(posedge link_clk or negedge rst_q[1]) begin
    if (!rst_q[1]) begin
      strobe_m_q <= 1'b0;
      strobe_s_q <= 1'b0;
      arm_m_q <= 1'b0;
      arm_s_q <= 1'b0;
      strobe_lvl_q <= 1'b0;
      flash_sel_q <= 1'b0;
    end else begin
      strobe_m_q <= strobe_pin;
      strobe_s_q <= strobe_m_q;
      arm_m_q <= flash_arm;
      arm_s_q <= arm_m_q;
      strobe_lvl_q <= strobe_lvl_d;
      flash_sel_q <= flash_sel_d;
    end
  end
  assign strobe_lvl = strobe_lvl_q;
  assign flash_sel = flash_sel_q;

  a_flash_follows: assert property (@(posedge link_clk) disable iff (!rst_q[1])
    flash_sel_q |-> $past(strobe_s_q) && $past(arm_s_q)) else $error("flash select without strobe and arm");
endmodule // lfmc_link

// *** lfmc_top.sv ***
`timescale 1ns/1ps
module lfmc_top
  import lfmc_pkg::*;
#(
  parameter int unsigned WDOG_CYCLES = WDOG_CYC,
  parameter int unsigned SAFETY_STEP_CYCLES = SAFETY_STEP_CYC
) (
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic LINK_CLK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic STROBE_PIN,
  input wire logic VMODE_PIN,
  input wire logic DCL_EN_PIN,
  input wire logic HIGH_CURRENT_SELECT_PIN,
  input wire logic VIN_GE_VOUT_PIN,
  input wire logic VIN_LOW_PIN,
  output logic CONV_EN,
  output logic LOAD_CONNECT,
  output logic [2:0] SINK_EN,
  output logic [11:0] LED_CURRENT,
  output logic [12:0] VOUT_MV,
  output logic VOLT_REG,
  output logic POWER_SAVE,
  output logic DOWN_MODE,
  output logic FLASH_ACTIVE,
  output logic FLASH_LEVEL_SEL
);
  // ==========================================================================
  // elaboration checks
  if (WDOG_CYCLES < 2 || SAFETY_STEP_CYCLES < 1 || SAFETY_STEP_CYCLES > 32'h0FFF_FFFF) begin : g_bad
    $error("lfmc_top: timer parameters out of range");
  end

  // ==========================================================================
  // functions
  function automatic logic [12:0] vout_mv(input logic [3:0] code);
    vout_mv = VOUT_BASE_MV + 13'(VOUT_STEP_MV * 13'(code));
  endfunction
  function automatic logic [11:0] led_qma(input logic [3:0] steps, input logic hc);
    led_qma = 12'((hc ? ISTEP_HC_QMA : ISTEP_DD_QMA) * 12'(steps));
  endfunction

  // ==========================================================================
  // reset release and pin synchronisers
  logic [1:0] rst_q;
  logic rst_n;
  logic [5:0] pin_m_q, pin_s_q;
  logic strobe_lvl;
  logic strobe_s, vmode_s, dcl_en_s, hc_s, vin_ge_s, vin_low_s;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      pin_m_q <= 6'h00;
      pin_s_q <= 6'h00;
    end else begin
      pin_m_q <= {VIN_LOW_PIN, VIN_GE_VOUT_PIN, HIGH_CURRENT_SELECT_PIN,
        DCL_EN_PIN, VMODE_PIN, strobe_lvl};
      pin_s_q <= pin_m_q;
    end
  end
  assign {vin_low_s, vin_ge_s, hc_s, dcl_en_s, vmode_s, strobe_s} = pin_s_q;

  // ==========================================================================
  // state
  lfmc_cfg_type cfg_q, cfg_d;
  lfmc_state_type state;
  logic trig_q, trig_d, run_q, run_d, hold_q, hold_d;
  logic [31:0] tmr_q, tmr_d, limit;
  logic [31:0] wd_q, wd_d;
  logic [3:0] step_q, step_d, tgt;
  logic [11:0] rcnt_q, rcnt_d, up_cyc;
  logic down_q, down_d, arm_q, arm_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic conv_q, conv_d;
  logic [2:0] sink_q, sink_d;
  logic [11:0] cur_q, cur_d;
  logic [12:0] vout_q, vout_d;
  logic volt_q, volt_d, psm_q, psm_d;
  logic vm_force, trig, wd_count, timeout, access, wr, mapped;
  logic [31:0] status;

  // ==========================================================================
  // next-state logic
  always_comb begin
    vm_force = cfg_q.voltage_mode_force | vmode_s;
    if (vm_force) begin
      state = ST_VOLTAGE;
    end else begin
      case (cfg_q.operating_mode)
        MODE_OFF: state = dcl_en_s ? ST_DCLIGHT : ST_SHUTDOWN;
        MODE_DCL: state = ST_DCLIGHT;
        MODE_FLASH: state = ST_FLASH;
        MODE_VOLT: state = ST_VOLTAGE;
        default: state = ST_SHUTDOWN;
      endcase
    end
    cfg_d = cfg_q;
    // strobe and software bit only count in flash mode
    trig = (state == ST_FLASH) & (strobe_s | cfg_q.software_flash_trigger);
    trig_d = trig;
    limit = (32'(cfg_q.flash_safety_timer_setting) + 32'h0000_0001) * SAFETY_STEP_CYCLES;
    run_d = run_q;
    tmr_d = tmr_q;
    hold_d = hold_q & trig;
    timeout = 1'b0;
    if (state != ST_FLASH) begin
      run_d = 1'b0;
      tmr_d = 32'h0000_0000;
      hold_d = 1'b0;
    end else if (run_q) begin
      if (tmr_q == limit - 32'h0000_0001) begin
        timeout = 1'b1;
        run_d = 1'b0;
        hold_d = trig;
      end else if (!cfg_q.strobe_type_select && !trig) begin
        run_d = 1'b0;
      end else begin
        tmr_d = tmr_q + 32'h0000_0001;
      end
    end else if (trig && !trig_q) begin
      run_d = 1'b1;
      tmr_d = 32'h0000_0000;
    end
    if (timeout) begin
      cfg_d.software_flash_trigger = 1'b0;
    end
    // dc-light watchdog
    wd_count = (state == ST_DCLIGHT || (state == ST_FLASH && !run_q)) && !dcl_en_s;
    wd_d = wd_count ? wd_q + 32'h0000_0001 : 32'h0000_0000;
    if (wd_count && wd_q == WDOG_CYCLES - 1) begin
      cfg_d.operating_mode = MODE_OFF;
      cfg_d.software_flash_trigger = 1'b0;
      wd_d = 32'h0000_0000;
    end
    // current ramp
    case (state)
      ST_DCLIGHT: tgt = cfg_q.dc_light_current_level;
      ST_FLASH: tgt = run_q ? cfg_q.flash_current_level : cfg_q.dc_light_current_level;
      default: tgt = 4'h0;
    endcase
    up_cyc = hc_s ? 12'(RAMP_UP_HC_CYC) : 12'(RAMP_UP_DD_CYC);
    step_d = step_q;
    rcnt_d = rcnt_q + 12'h001;
    if (step_q == tgt) begin
      rcnt_d = 12'h000;
    end else if (step_q < tgt && rcnt_q >= up_cyc - 12'h001) begin
      step_d = step_q + 4'h1;
      rcnt_d = 12'h000;
    end else if (step_q > tgt && rcnt_q >= 12'(RAMP_DN_CYC) - 12'h001) begin
      step_d = step_q - 4'h1;
      rcnt_d = 12'h000;
    end
    // down-conversion hysteresis
    down_d = down_q;
    if (state != ST_VOLTAGE) begin
      down_d = 1'b0;
    end else if (vin_ge_s) begin
      down_d = 1'b1;
    end else if (vin_low_s) begin
      down_d = 1'b0;
    end
    arm_d = (state == ST_FLASH) & ~hold_d;
    // outputs
    conv_d = state != ST_SHUTDOWN;
    sink_d = (state == ST_DCLIGHT || state == ST_FLASH) ? cfg_q.led_sink_enables : 3'h0;
    cur_d = led_qma(step_q, hc_s);
    vout_d = vout_mv(vmode_s ? VM_PRESET_CODE : cfg_q.output_voltage_code);
    volt_d = state == ST_VOLTAGE;
    psm_d = cfg_q.power_save_enable | down_q;
    // apb slave
    status = 32'h0000_0000;
    status[STAT_STATE_LSB +: 2] = state;
    status[STAT_RUN_BIT] = run_q;
    status[STAT_HOLD_BIT] = hold_q;
    status[STAT_DOWN_BIT] = down_q;
    status[STAT_VMPIN_BIT] = vmode_s;
    status[STAT_HC_BIT] = hc_s;
    status[STAT_CUR_LSB +: 12] = cur_q;
    access = PSEL & PENABLE;
    mapped = PADDR == CTRL_OFS || PADDR == LEVEL_OFS || PADDR == VOUT_OFS || PADDR == STATUS_OFS;
    pready_d = access & ~pready_q;
    pslverr_d = access & ~pready_q & ~mapped;
    prdata_d = prdata_q;
    if (access && !pready_q) begin
      case (PADDR)
        CTRL_OFS: prdata_d = {26'h0, cfg_q.strobe_type_select, cfg_q.power_save_enable,
          cfg_q.voltage_mode_force, cfg_q.software_flash_trigger, cfg_q.operating_mode};
        LEVEL_OFS: prdata_d = {21'h0, cfg_q.led_sink_enables, cfg_q.flash_current_level,
          cfg_q.dc_light_current_level};
        VOUT_OFS: prdata_d = {25'h0, cfg_q.flash_safety_timer_setting, cfg_q.output_voltage_code};
        STATUS_OFS: prdata_d = status;
        default: prdata_d = 32'h0000_0000;
      endcase
    end
    wr = access & pready_q & PWRITE & ~pslverr_q;
    if (wr) begin
      case (PADDR)
        CTRL_OFS: begin
          cfg_d.operating_mode = PWDATA[CTRL_MODE_LSB +: 2];
          cfg_d.software_flash_trigger = PWDATA[CTRL_SWTRIG_BIT]; // software write wins over timeout
          cfg_d.voltage_mode_force = PWDATA[CTRL_VMF_BIT];
          cfg_d.power_save_enable = PWDATA[CTRL_PSM_BIT];
          cfg_d.strobe_type_select = PWDATA[CTRL_STRTYPE_BIT];
          wd_d = 32'h0000_0000;
        end
        LEVEL_OFS: begin
          cfg_d.dc_light_current_level = PWDATA[LEVEL_DC_LSB +: 4];
          cfg_d.flash_current_level = PWDATA[LEVEL_FL_LSB +: 4];
          cfg_d.led_sink_enables = PWDATA[LEVEL_SINK_LSB +: 3];
        end
        VOUT_OFS: begin
          cfg_d.output_voltage_code = PWDATA[VOUT_CODE_LSB +: 4];
          cfg_d.flash_safety_timer_setting = PWDATA[VOUT_TIMER_LSB +: 3];
        end
        default: cfg_d = cfg_d;
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '{operating_mode: MODE_RST, software_flash_trigger: 1'b0, voltage_mode_force: 1'b0,
        power_save_enable: 1'b0, strobe_type_select: 1'b0, dc_light_current_level: LEVEL_RST,
        flash_current_level: LEVEL_RST, led_sink_enables: SINK_RST, output_voltage_code: VCODE_RST,
        flash_safety_timer_setting: TIMER_RST};
      trig_q <= 1'b0;
      run_q <= 1'b0;
      hold_q <= 1'b0;
      tmr_q <= 32'h0000_0000;
      wd_q <= 32'h0000_0000;
      step_q <= 4'h0;
      rcnt_q <= 12'h000;
      down_q <= 1'b0;
      arm_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      conv_q <= 1'b0;
      sink_q <= 3'h0;
      cur_q <= 12'h000;
      vout_q <= 13'h0000;
      volt_q <= 1'b0;
      psm_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      trig_q <= trig_d;
      run_q <= run_d;
      hold_q <= hold_d;
      tmr_q <= tmr_d;
      wd_q <= wd_d;
      step_q <= step_d;
      rcnt_q <= rcnt_d;
      down_q <= down_d;
      arm_q <= arm_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      conv_q <= conv_d;
      sink_q <= sink_d;
      cur_q <= cur_d;
      vout_q <= vout_d;
      volt_q <= volt_d;
      psm_q <= psm_d;
    end
  end

  // ==========================================================================
  // link side
  lfmc_link u_link (
    .link_clk(LINK_CLK),
    .nrst(NRST),
    .strobe_pin(STROBE_PIN),
    .flash_arm(arm_q),
    .strobe_lvl(strobe_lvl),
    .flash_sel(FLASH_LEVEL_SEL)
  );

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign CONV_EN = conv_q;
  assign LOAD_CONNECT = conv_q;
  assign SINK_EN = sink_q;
  assign LED_CURRENT = cur_q;
  assign VOUT_MV = vout_q;
  assign VOLT_REG = volt_q;
  assign POWER_SAVE = psm_q;
  assign DOWN_MODE = down_q;
  assign FLASH_ACTIVE = run_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    PSEL && PENABLE && !pready_q;
  endsequence
  sequence s_answer;
    pready_q ##1 !pready_q;
  endsequence
  a_shutdown_off: assert property (state == ST_SHUTDOWN |=> !conv_q && sink_q == 3'h0)
    else $error("shutdown left converter or sinks on");
  a_dcl_no_flash: assert property (state == ST_DCLIGHT |=> !run_q)
    else $error("flash timer ran in dc light");
  a_wdog_expiry: assert property (wd_count && wd_q == WDOG_CYCLES - 1 && !wr
    |=> cfg_q.operating_mode == MODE_OFF) else $error("watchdog expiry did not shut down");
  a_volt_sinks: assert property (state == ST_VOLTAGE |=> sink_q == 3'h0 && !run_q && volt_q)
    else $error("voltage mode with sinks or timer active");
  a_vm_force: assert property (vmode_s |-> state == ST_VOLTAGE ##1 vout_q == vout_mv(VM_PRESET_CODE))
    else $error("voltage pin did not force preset");
  a_vout_range: assert property (volt_q |-> vout_q >= VOUT_BASE_MV && vout_q <= vout_mv(4'hF))
    else $error("output voltage out of range");
  a_timer_stop: assert property (run_q && tmr_q == limit - 1 && !wr
    |=> !run_q && !cfg_q.software_flash_trigger) else $error("safety timeout missed");
  a_level_stop: assert property (run_q && !cfg_q.strobe_type_select && !trig |=> !run_q)
    else $error("level strobe low did not stop timer");
  a_ramp_step: assert property ($changed(step_q) |=> $stable(step_q) [*2])
    else $error("ramp stepped too fast");
  a_psm_down: assert property (down_q |=> psm_q)
    else $error("power save off in down mode");
  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("apb answer not one cycle");
endmodule // lfmc_top

// *** lfmc_cam_model.sv ***
`timescale 1ns/1ps
module lfmc_cam_model (
  input wire logic link_clk,
  input wire logic fire,
  input wire logic [3:0] lag,
  output logic strobe
);
  // ==========================================================================
  // camera strobe: rises lag+1 link cycles after fire, drops with it
  logic [3:0] wait_q = 4'h0;
  logic strobe_q = 1'b0;
  assign strobe = strobe_q;
  always @(posedge link_clk) begin
    if (!fire) begin
      wait_q <= 4'h0;
      strobe_q <= 1'b0;
    end else if (wait_q < lag) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      strobe_q <= 1'b1;
    end
  end
endmodule // lfmc_cam_model

// *** led_flash_mode_control_tb_top.sv ***
`timescale 1ns/1ps
module led_flash_mode_control_tb_top;
  import lfmc_pkg::*;
  localparam int WDOG = 5000;
  localparam int STEP = 1000;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, err, strobe;
  logic vmode = 1'b0, dcl = 1'b0, hc = 1'b0, vge = 1'b0, vlow = 1'b0, fire = 1'b0;
  logic [3:0] lag = 4'h0;
  logic conv_en, load_conn, volt_reg, psave, down, fl_act, fl_sel;
  logic [2:0] sink_en;
  logic [11:0] led_i;
  logic [12:0] vout_mv;
  logic [7:0] rnd = 8'h35;
  int n_mismatch = 0;
  int checks = 0;
  int f;

  always #5 clk = ~clk;
  initial begin
    #17;
    forever #62.5 lclk = ~lclk;
  end

  lfmc_cam_model lfmc_cam_model_inst (.link_clk(lclk), .fire(fire), .lag(lag), .strobe(strobe));

  lfmc_top #(.WDOG_CYCLES(WDOG), .SAFETY_STEP_CYCLES(STEP)) lfmc_top_inst (
    .REF_CLK(clk), .NRST(nrst), .LINK_CLK(lclk),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .STROBE_PIN(strobe), .VMODE_PIN(vmode), .DCL_EN_PIN(dcl), .HIGH_CURRENT_SELECT_PIN(hc),
    .VIN_GE_VOUT_PIN(vge), .VIN_LOW_PIN(vlow),
    .CONV_EN(conv_en), .LOAD_CONNECT(load_conn), .SINK_EN(sink_en), .LED_CURRENT(led_i),
    .VOUT_MV(vout_mv), .VOLT_REG(volt_reg), .POWER_SAVE(psave), .DOWN_MODE(down),
    .FLASH_ACTIVE(fl_act), .FLASH_LEVEL_SEL(fl_sel)
  );

  // ==========================================================================
  // helpers
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] vout_exp(input int c);
    return 32'(VOUT_BASE_MV + VOUT_STEP_MV * c);
  endfunction
  function automatic logic [31:0] cur_exp(input int lvl, input bit h);
    return 32'((h ? ISTEP_HC_QMA : ISTEP_DD_QMA) * lvl);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #500_000;
    n_mismatch++;
    finish_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    cyc(5);
    nrst <= 1'b1;
    cyc(3);
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    apb(1'b0, LEVEL_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_0700);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(err, 1'b1);
    chk(conv_en, 1'b0);
    chk(load_conn, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, VOUT_OFS, 32'(c));
      cyc(3);
      chk(vout_mv, vout_exp(c));
    end
    rnd = lfsr(rnd);
    apb(1'b1, VOUT_OFS, {28'h0, rnd[3:0]});
    cyc(3);
    chk(vout_mv, vout_exp(rnd[3:0]));
    chk(volt_reg, 1'b1);
    chk(sink_en, 3'h0);
    apb(1'b0, STATUS_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_0003);
    fire <= 1'b1;
    cyc(60);
    chk(fl_act, 1'b0);
    fire <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'h0000_0013);
    cyc(4);
    chk(psave, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    vge <= 1'b1;
    cyc(6);
    chk(down, 1'b1);
    chk(psave, 1'b1);
    vge <= 1'b0;
    vlow <= 1'b1;
    cyc(6);
    chk(down, 1'b0);
    chk(psave, 1'b0);
    vlow <= 1'b0;
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    vmode <= 1'b1;
    cyc(6);
    chk(volt_reg, 1'b1);
    chk(vout_mv, vout_exp(VM_PRESET_CODE));
    vmode <= 1'b0;
    cyc(6);
    chk(conv_en, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h0000_0008);
    cyc(4);
    chk(volt_reg, 1'b1);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    dcl <= 1'b1;
    cyc(6);
    chk(conv_en, 1'b1);
    dcl <= 1'b0;
    // dc light, direct drive, strobe must be ignored
    rnd = lfsr(rnd);
    f = 1 + rnd[3:0] % 15;
    apb(1'b1, LEVEL_OFS, 32'h0000_0701 | 32'(f << 4));
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    fire <= 1'b1;
    cyc(60);
    chk(fl_act, 1'b0);
    fire <= 1'b0;
    cyc(1300);
    chk(led_i, cur_exp(1, 1'b0));
    chk(sink_en, 3'h7);
    hc <= 1'b1;
    cyc(100);
    chk(led_i, cur_exp(1, 1'b1));
    cyc(WDOG);
    chk(conv_en, 1'b0);
    // flash, level strobe
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
    fire <= 1'b1;
    cyc(60);
    chk(fl_act, 1'b1);
    chk(fl_sel, 1'b1);
    cyc(f * 50 + 40);
    chk(led_i, cur_exp(f, 1'b1));
    fire <= 1'b0;
    cyc(60);
    chk(fl_act, 1'b0);
    chk(fl_sel, 1'b0);
    cyc(820);
    chk(led_i, cur_exp(1, 1'b1));
    fire <= 1'b1;
    cyc(STEP + 200);
    chk(fl_act, 1'b0);
    fire <= 1'b0;
    // let the synced strobe fall so the software bit makes a fresh rising edge
    cyc(60);
    apb(1'b1, CTRL_OFS, 32'h0000_0006);
    cyc(20);
    chk(fl_act, 1'b1);
    cyc(STEP + 100);
    apb(1'b0, CTRL_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_0002);
    // edge strobe with a slow camera
    lag <= 4'h3;
    apb(1'b1, CTRL_OFS, 32'h0000_0022);
    fire <= 1'b1;
    cyc(80);
    fire <= 1'b0;
    cyc(80);
    chk(fl_act, 1'b1);
    cyc(STEP);
    chk(fl_act, 1'b0);
    finish_test();
  end
endmodule // led_flash_mode_control_tb_top
